// ### verilog/interrupt_mask_mode_vector.v
// Strobed register access is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "interrupt_mask_mode_vector_map.vh"

module interrupt_mask_mode_vector (
    // Clock and reset
    input  wire        clk,
    input  wire        reset_n,
    // Register port
    input  wire [7:0]  addr,
    input  wire [7:0]  wrData,
    input  wire        wrStrobe,
    input  wire        rdStrobe,
    output reg  [7:0]  rdData,
    // Interrupt sources
    input  wire [31:0] channelIn,
    input  wire        powerFailInput_n,
    // Toward the processor
    output wire        procRequest,
    output wire        processorTrapInput_n,
    // Block interrupt
    output wire        irq
);

    // Synchroniser first and second stages
    reg  [31:0] chanS1_ff;
    reg  [31:0] chanS2_ff;
    // Active-level view of last cycle
    reg  [31:0] activePrev_ff;
    // Power-fail synchroniser and history
    reg         pfS1_ff;
    reg         pfS2_ff;
    reg         pfPrev_ff;

    // Configuration registers
    reg  [31:0] enable_ff;
    reg  [31:0] mode_ff;
    reg  [31:0] polarity_ff;
    // Pending status of all channels
    reg  [31:0] pending_ff;
    reg  [31:0] nxt_pending;
    // Vector register
    reg  [7:0]  vector_ff;
    reg  [7:0]  nxt_vector;
    // Trap state
    reg         trapStatus_ff;
    reg         trapArm_ff;
    reg         trapArmLocked_ff;
    // Event status and mask
    reg  [1:0]  evStatus_ff;
    reg  [1:0]  evMask_ff;
    reg         reqPrev_ff;

    // Active level per channel after polarity
    wire [31:0] activeNow;
    // Enabled and pending channels
    wire [31:0] competing;
    // Power-fail falling edge seen
    wire        pfFall;
    // Trap fires this cycle
    wire        trapFire;
    // Software reads trap status
    wire        trapRead;
    // Write decode helpers
    wire        wrPend;
    wire [1:0]  wrByte;
    wire [31:0] wrMaskBits;

    // Polarity flips each channel to active-high
    assign activeNow = chanS2_ff ^ polarity_ff;

    // Channel zero never competes
    assign competing = pending_ff & enable_ff & 32'hFFFFFFFE;

    // Request line to the processor
    assign procRequest = |competing;

    // Falling edge on the synchronised input
    assign pfFall = pfPrev_ff & ~pfS2_ff;

    // Either arm bit allows the trap
    assign trapFire = pfFall & (trapArm_ff | trapArmLocked_ff);

    // Read of the trap status register
    assign trapRead = rdStrobe & (addr == `OFS_TRAPST);

    // Trap input to the processor is active low
    assign processorTrapInput_n = ~trapStatus_ff;

    // Level interrupt from unmasked events
    assign irq = |(evStatus_ff & evMask_ff);

    // Pending write hits one of four bytes
    assign wrPend = wrStrobe & (addr[7:2] == 6'h00);
    assign wrByte = addr[1:0];

    // Spread the written byte to its lane
    assign wrMaskBits = wrPend ? ({24'h000000, wrData} << {wrByte, 3'b000})
                               : 32'h00000000;

    // Two-stage synchronisers for outside inputs
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            chanS1_ff <= 32'h00000000;
            chanS2_ff <= 32'h00000000;
            pfS1_ff   <= 1'b1;
            pfS2_ff   <= 1'b1;
            pfPrev_ff <= 1'b1;
        end else begin
            chanS1_ff <= channelIn;
            chanS2_ff <= chanS1_ff;
            pfS1_ff   <= powerFailInput_n;
            pfS2_ff   <= pfS1_ff;
            pfPrev_ff <= pfS2_ff;
        end
    end

    // Edge history of each active level
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            activePrev_ff <= 32'h00000000;
        end else begin
            activePrev_ff <= activeNow;
        end
    end

    // Next pending state per channel
    always @* begin : pendCalc
        integer i;
        nxt_pending = pending_ff;
        for (i = 0; i < 32; i = i + 1) begin
            if (mode_ff[i]) begin
                // Edge mode: set on edge, set beats clear
                if (activeNow[i] & ~activePrev_ff[i]) begin
                    nxt_pending[i] = 1'b1;
                end else if (wrMaskBits[i]) begin
                    nxt_pending[i] = 1'b0;
                end
            end else begin
                // Level mode: follows input, writes ignored
                nxt_pending[i] = activeNow[i];
            end
        end
    end

    // Pending register
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pending_ff <= 32'h00000000;
        end else begin
            pending_ff <= nxt_pending;
        end
    end

    // Priority encoder, highest channel wins
    always @* begin : vecCalc
        integer j;
        nxt_vector = `VECTOR_BASE;
        for (j = 1; j < 32; j = j + 1) begin
            if (competing[j]) begin
                nxt_vector = `VECTOR_BASE + j[7:0];
            end
        end
    end

    // Vector refreshed every clock
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            vector_ff <= `RST_VECTOR;
        end else begin
            vector_ff <= nxt_vector;
        end
    end

    // Configuration register writes
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            enable_ff   <= {4{`RST_ENA}};
            mode_ff     <= {`RST_MODE3, `RST_MODE2,
                            `RST_MODE1, `RST_MODE0};
            polarity_ff <= {4{`RST_POL}};
            evMask_ff   <= `RST_EV;
        end else if (wrStrobe) begin
            if (addr == `OFS_ENA0) begin
                // Bit zero stays clear
                enable_ff[7:0] <= {wrData[7:1], 1'b0};
            end else if (addr == `OFS_ENA1) begin
                enable_ff[15:8] <= wrData;
            end else if (addr == `OFS_ENA2) begin
                enable_ff[23:16] <= wrData;
            end else if (addr == `OFS_ENA3) begin
                enable_ff[31:24] <= wrData;
            end else if (addr == `OFS_MODE0) begin
                mode_ff[7:0] <= wrData;
            end else if (addr == `OFS_MODE1) begin
                mode_ff[15:8] <= wrData;
            end else if (addr == `OFS_MODE2) begin
                mode_ff[23:16] <= wrData;
            end else if (addr == `OFS_MODE3) begin
                mode_ff[31:24] <= wrData;
            end else if (addr == `OFS_POL0) begin
                polarity_ff[7:0] <= wrData;
            end else if (addr == `OFS_POL1) begin
                polarity_ff[15:8] <= wrData;
            end else if (addr == `OFS_POL2) begin
                polarity_ff[23:16] <= wrData;
            end else if (addr == `OFS_POL3) begin
                polarity_ff[31:24] <= wrData;
            end else if (addr == `OFS_EVMASK) begin
                evMask_ff <= wrData[1:0];
            end
        end
    end

    // Trap arm bits: one-shot and locked
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            trapArm_ff       <= 1'b0;
            trapArmLocked_ff <= 1'b0;
        end else begin
            // Locked arm only leaves by reset
            if (wrStrobe && addr == `OFS_TRAPCTL
                && wrData[`TRAPCTL_LOCK]) begin
                trapArmLocked_ff <= 1'b1;
            end
            // One-shot arm drops when it fires
            if (trapFire) begin
                trapArm_ff <= 1'b0;
            end else if (wrStrobe && addr == `OFS_TRAPCTL) begin
                trapArm_ff <= wrData[`TRAPCTL_ARM];
            end
        end
    end

    // Trap status: fire wins over read clear
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            trapStatus_ff <= 1'b0;
        end else if (trapFire) begin
            trapStatus_ff <= 1'b1;
        end else if (trapRead) begin
            trapStatus_ff <= 1'b0;
        end
    end

    // Event flags, set wins over write-one clear
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            evStatus_ff <= `RST_EV;
            reqPrev_ff  <= 1'b0;
        end else begin
            reqPrev_ff <= procRequest;
            // Trap event
            if (trapFire) begin
                evStatus_ff[`EV_TRAP] <= 1'b1;
            end else if (wrStrobe && addr == `OFS_EVSTAT
                         && wrData[`EV_TRAP]) begin
                evStatus_ff[`EV_TRAP] <= 1'b0;
            end
            // New processor request event
            if (procRequest && !reqPrev_ff) begin
                evStatus_ff[`EV_REQ] <= 1'b1;
            end else if (wrStrobe && addr == `OFS_EVSTAT
                         && wrData[`EV_REQ]) begin
                evStatus_ff[`EV_REQ] <= 1'b0;
            end
        end
    end

    // Read data, valid the cycle after the strobe
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdData <= 8'h00;
        end else if (rdStrobe) begin
            if (addr == `OFS_PEND0) begin
                rdData <= pending_ff[7:0];
            end else if (addr == `OFS_PEND1) begin
                rdData <= pending_ff[15:8];
            end else if (addr == `OFS_PEND2) begin
                rdData <= pending_ff[23:16];
            end else if (addr == `OFS_PEND3) begin
                rdData <= pending_ff[31:24];
            end else if (addr == `OFS_ENA0) begin
                rdData <= enable_ff[7:0];
            end else if (addr == `OFS_ENA1) begin
                rdData <= enable_ff[15:8];
            end else if (addr == `OFS_ENA2) begin
                rdData <= enable_ff[23:16];
            end else if (addr == `OFS_ENA3) begin
                rdData <= enable_ff[31:24];
            end else if (addr == `OFS_MODE0) begin
                rdData <= mode_ff[7:0];
            end else if (addr == `OFS_MODE1) begin
                rdData <= mode_ff[15:8];
            end else if (addr == `OFS_MODE2) begin
                rdData <= mode_ff[23:16];
            end else if (addr == `OFS_MODE3) begin
                rdData <= mode_ff[31:24];
            end else if (addr == `OFS_POL0) begin
                rdData <= polarity_ff[7:0];
            end else if (addr == `OFS_POL1) begin
                rdData <= polarity_ff[15:8];
            end else if (addr == `OFS_POL2) begin
                rdData <= polarity_ff[23:16];
            end else if (addr == `OFS_POL3) begin
                rdData <= polarity_ff[31:24];
            end else if (addr == `OFS_VECTOR) begin
                // Top two bits always zero
                rdData <= {2'b00, vector_ff[5:0]};
            end else if (addr == `OFS_TRAPST) begin
                rdData <= {7'h00, trapStatus_ff};
            end else if (addr == `OFS_TRAPCTL) begin
                rdData <= {5'h00, trapArmLocked_ff,
                           pfS2_ff, trapArm_ff};
            end else if (addr == `OFS_EVSTAT) begin
                rdData <= {6'h00, evStatus_ff};
            end else if (addr == `OFS_EVMASK) begin
                rdData <= {6'h00, evMask_ff};
            end else begin
                // Unmapped reads as zero
                rdData <= 8'h00;
            end
        end else begin
            // Data stands one cycle only
            rdData <= 8'h00;
        end
    end

endmodule
`default_nettype wire

// ### verilog/interrupt_mask_mode_vector_map.vh
`ifndef INTERRUPT_MASK_MODE_VECTOR_MAP_VH
`define INTERRUPT_MASK_MODE_VECTOR_MAP_VH
// Register offsets
`define OFS_PEND0      8'h00
`define OFS_PEND1      8'h01
`define OFS_PEND2      8'h02
`define OFS_PEND3      8'h03
`define OFS_ENA0       8'h04
`define OFS_ENA1       8'h05
`define OFS_ENA2       8'h06
`define OFS_ENA3       8'h07
`define OFS_MODE0      8'h08
`define OFS_MODE1      8'h09
`define OFS_MODE2      8'h0A
`define OFS_MODE3      8'h0B
`define OFS_POL0       8'h0C
`define OFS_POL1       8'h0D
`define OFS_POL2       8'h0E
`define OFS_POL3       8'h0F
`define OFS_VECTOR     8'h10
`define OFS_TRAPST     8'h11
`define OFS_TRAPCTL    8'h12
`define OFS_EVSTAT     8'h13
`define OFS_EVMASK     8'h14
// Reset values
`define RST_ENA        8'h00
`define RST_MODE0      8'h00
`define RST_MODE1      8'h00
`define RST_MODE2      8'h1D
`define RST_MODE3      8'h4C
`define RST_POL        8'h00
`define RST_VECTOR     8'h10
`define RST_EV         2'h0
// Vector base added to the winning channel number
`define VECTOR_BASE    8'h10
// Trap control fields
`define TRAPCTL_ARM    0
`define TRAPCTL_PFST   1
`define TRAPCTL_LOCK   2
// Event status fields
`define EV_TRAP        0
`define EV_REQ         1
`endif

// ### sim/interrupt_mask_mode_vector_sva.sv
`timescale 1ns/1ns
`default_nettype none
module interrupt_mask_mode_vector_sva (
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset_n,
    // Register port
    input wire logic [7:0]  addr,
    input wire logic [7:0]  wrData,
    input wire logic        wrStrobe,
    input wire logic        rdStrobe,
    input wire logic [7:0]  rdData,
    // Sources and outputs
    input wire logic [31:0] channelIn,
    input wire logic        powerFailInput_n,
    input wire logic        procRequest,
    input wire logic        processorTrapInput_n,
    input wire logic        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Reads of the vector and of the trap status
    wire vecRd  = rdStrobe && addr == 8'h10;
    wire trapRd = rdStrobe && addr == 8'h11;
    property p_rdIdle; !rdStrobe |=> rdData == 8'h00; endproperty
    a_rdIdle: assert property (p_rdIdle) else $error("read data outside its cycle");
    property p_vecRange; vecRd |=> rdData >= 8'h10 && rdData <= 8'h2F; endproperty
    a_vecRange: assert property (p_vecRange) else $error("vector out of range");
    property p_vecIdle; vecRd && !procRequest && !$past(procRequest) |=> rdData == 8'h10;
    endproperty
    a_vecIdle: assert property (p_vecIdle) else $error("idle vector wrong");
    property p_vecBusy; vecRd && procRequest && $past(procRequest) |=> rdData > 8'h10;
    endproperty
    a_vecBusy: assert property (p_vecBusy) else $error("busy vector idle");
    property p_trapRead; trapRd |=> rdData == {7'h00, !$past(processorTrapInput_n)};
    endproperty
    a_trapRead: assert property (p_trapRead) else $error("trap status read wrong");
    property p_trapClear; trapRd && powerFailInput_n && $past(powerFailInput_n)
        && $past(powerFailInput_n, 2) && $past(powerFailInput_n, 3) |=> processorTrapInput_n;
    endproperty
    a_trapClear: assert property (p_trapClear) else $error("trap not cleared by read");
    property p_trapFell; $fell(processorTrapInput_n)
        |-> !$past(powerFailInput_n, 3) && $past(powerFailInput_n, 4); endproperty
    a_trapFell: assert property (p_trapFell) else $error("trap set without pin fall");
    property p_trapRise; $rose(processorTrapInput_n) |-> $past(trapRd); endproperty
    a_trapRise: assert property (p_trapRise) else $error("trap cleared without read");
    // Main scenarios
    c_vecBusy: cover property (vecRd && procRequest);
    c_trapSet: cover property ($fell(processorTrapInput_n));
    c_irqRise: cover property ($rose(irq));
endmodule
`default_nettype wire

// ### sim/interrupt_source_model.sv
`timescale 1ns/1ns
`default_nettype none
module interrupt_source_model (
    // Commanded source levels
    input  wire logic [31:0] chanLevel,
    input  wire logic        pfLevel,
    // Toward the block
    output wire logic [31:0] channelIn,
    output wire logic        powerFailInput_n
);
    // Sources follow commands that change just after a clock edge
    assign channelIn        = chanLevel;
    assign powerFailInput_n = pfLevel;
endmodule
`default_nettype wire

// ### sim/tb_interrupt_mask_mode_vector.sv
`timescale 1ns/1ns
`default_nettype none
module tb_interrupt_mask_mode_vector;
    // Clock, reset and register port
    logic        clk;
    logic        reset_n;
    logic [7:0]  addr;
    logic [7:0]  wrData;
    logic        wrStrobe;
    logic        rdStrobe;
    wire  [7:0]  rdData;
    // Sources and outputs
    logic [31:0] chanLevel;
    logic        pfLevel;
    wire  [31:0] channelIn;
    wire         powerFailInput_n;
    wire         procRequest;
    wire         processorTrapInput_n;
    wire         irq;
    // Counters, index and reset values of 04h..11h
    integer      failures;
    integer      comparisons;
    integer      i;
    logic [7:0]  rstVal [0:13];
    interrupt_mask_mode_vector u_dut (.clk(clk), .reset_n(reset_n), .addr(addr),
        .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
        .channelIn(channelIn), .powerFailInput_n(powerFailInput_n),
        .procRequest(procRequest), .processorTrapInput_n(processorTrapInput_n), .irq(irq));
    interrupt_source_model u_src (.chanLevel(chanLevel), .pfLevel(pfLevel),
        .channelIn(channelIn), .powerFailInput_n(powerFailInput_n));
    // Compare and count
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One-cycle register write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge clk);
        wrStrobe <= 1'b0;
    endtask
    // One-cycle read, data sampled in the following cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge clk);
        rdStrobe <= 1'b0;
        @(negedge clk);
        check($sformatf("reg %h", a), exp, rdData);
    endtask
    // New source levels, then room for sync, pending and vector
    task automatic src(input logic [31:0] c, input logic p);
        @(posedge clk);
        chanLevel <= c;
        pfLevel <= p;
        repeat (7) @(posedge clk);
        @(negedge clk);
    endtask
    // Verdict and end of run
    task automatic complete_run();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // 50 ns clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Hang guard
    initial begin
        repeat (5000) @(posedge clk);
        failures = failures + 1;
        complete_run();
    end
    // Main sequence
    initial begin
        reset_n = 1'b0;
        addr = 8'h00;
        wrData = 8'h00;
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
        chanLevel = 32'h00000000;
        pfLevel = 1'b1;
        failures = 0;
        comparisons = 0;
        rstVal = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1D, 8'h4C,
                   8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00};
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        for (i = 0; i < 14; i = i + 1) rd(8'h04 + i[7:0], rstVal[i]);
        rd(8'h20, 8'h00);
        // Enable read back, vector ignores writes
        wr(8'h06, 8'hA5);
        rd(8'h06, 8'hA5);
        wr(8'h10, 8'hFF);
        rd(8'h10, 8'h10);
        // Channel 0 has no enable and never competes
        wr(8'h04, 8'hFF);
        rd(8'h04, 8'hFE);
        src(32'h00000001, 1'b1);
        check("request", 8'h00, {7'h00, procRequest});
        rd(8'h10, 8'h10);
        // Level channels 17, 29 and 31 compete
        wr(8'h06, 8'hFF);
        wr(8'h07, 8'hFF);
        src(32'h20020000, 1'b1);
        check("request", 8'h01, {7'h00, procRequest});
        rd(8'h10, 8'h2D);
        src(32'hA0020000, 1'b1);
        rd(8'h10, 8'h2F);
        // Masked channels stay pending, level bits ignore clears
        wr(8'h07, 8'h00);
        rd(8'h10, 8'h21);
        rd(8'h03, 8'hA0);
        wr(8'h03, 8'hA0);
        rd(8'h03, 8'hA0);
        // Level-low channel 17
        wr(8'h0E, 8'h02);
        src(32'h00000000, 1'b1);
        rd(8'h02, 8'h02);
        wr(8'h0E, 8'h00);
        // Rising edges on 16 and 18 stick until written with one
        src(32'h00050000, 1'b1);
        src(32'h00000000, 1'b1);
        rd(8'h02, 8'h05);
        rd(8'h10, 8'h22);
        wr(8'h02, 8'h05);
        rd(8'h02, 8'h00);
        // Falling edge on 18 with polarity set
        src(32'h00040000, 1'b1);
        wr(8'h02, 8'h04);
        wr(8'h0E, 8'h04);
        src(32'h00000000, 1'b1);
        rd(8'h02, 8'h04);
        // Channel 16 in level mode keeps nothing after a pulse
        wr(8'h0A, 8'h00);
        src(32'h00010000, 1'b1);
        src(32'h00000000, 1'b1);
        rd(8'h02, 8'h04);
        // Request event stays masked, then an unarmed fall is ignored
        check("irq", 8'h00, {7'h00, irq});
        wr(8'h14, 8'h01);
        src(32'h00000000, 1'b0);
        rd(8'h11, 8'h00);
        // One-shot arm fires once
        src(32'h00000000, 1'b1);
        wr(8'h12, 8'h01);
        src(32'h00000000, 1'b0);
        check("trap pin", 8'h00, {7'h00, processorTrapInput_n});
        check("irq", 8'h01, {7'h00, irq});
        rd(8'h11, 8'h01);
        rd(8'h11, 8'h00);
        wr(8'h13, 8'h01);
        // Let the clear settle before looking
        @(negedge clk);
        check("irq", 8'h00, {7'h00, irq});
        src(32'h00000000, 1'b1);
        src(32'h00000000, 1'b0);
        rd(8'h11, 8'h00);
        // Locked arm keeps firing
        wr(8'h12, 8'h04);
        for (i = 0; i < 2; i = i + 1) begin
            src(32'h00000000, 1'b1);
            src(32'h00000000, 1'b0);
            rd(8'h11, 8'h01);
        end
        // Request event through its mask, then write-one clear
        wr(8'h13, 8'h01);
        wr(8'h14, 8'h02);
        rd(8'h13, 8'h02);
        check("irq", 8'h01, {7'h00, irq});
        check("request", 8'h01, {7'h00, procRequest});
        wr(8'h13, 8'h02);
        @(negedge clk);
        check("irq", 8'h00, {7'h00, irq});
        // Reset in mid-run clears a set trap and restores defaults
        src(32'h00000000, 1'b1);
        src(32'h00000000, 1'b0);
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rd(8'h11, 8'h00);
        rd(8'h0B, 8'h4C);
        complete_run();
    end
endmodule
bind interrupt_mask_mode_vector interrupt_mask_mode_vector_sva u_sva (.clk(clk),
    .reset_n(reset_n), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe), .rdData(rdData), .channelIn(channelIn),
    .powerFailInput_n(powerFailInput_n), .procRequest(procRequest),
    .processorTrapInput_n(processorTrapInput_n), .irq(irq));
`default_nettype wire
